// File: design/csx_core.sv
// Execution core for a subset of an 8-bit instruction set
`timescale 1ns/1ps
`default_nettype none

module csx_core (
	input  wire logic                         ref_clk,
	input  wire logic                         srst,
	input  wire logic                         instr_valid,
	input  wire logic [csx_pkg::INSTR_W-1:0]  instr,
	input  wire logic [csx_pkg::PC_W-1:0]     stack_top,
	output logic      [csx_pkg::DATA_W-1:0]   acc,
	output logic      [csx_pkg::DATA_W-1:0]   option_cfg,
	output logic                              zero_flag,
	output logic      [csx_pkg::PC_W-1:0]     pc,
	output logic                              retire,
	output logic                              discard,
	output logic                              pc_return,
	output logic                              file_wr_en,
	output logic      [csx_pkg::ADDR_W-1:0]   file_wr_addr,
	output logic      [csx_pkg::DATA_W-1:0]   file_wr_data
);

	// ----------------------------------------------------------------
	// Types and declarations
	// ----------------------------------------------------------------
	typedef enum logic {
		CSX_ST_EXEC,
		CSX_ST_FLUSH
	} csx_state_e;

	csx_state_e                  state_reg;
	csx_state_e                  state_next;

	csx_pkg::csx_dec_s           dec;
	csx_pkg::csx_dec_s           dec_eff;
	csx_pkg::csx_res_s           res;

	logic [3:0]                  opc;
	logic [csx_pkg::DATA_W-1:0]  fval;
	logic                        exec_now;
	logic                        flush_now;

	logic [csx_pkg::DATA_W-1:0]  acc_reg;
	logic [csx_pkg::DATA_W-1:0]  acc_next;
	logic [csx_pkg::DATA_W-1:0]  opt_reg;
	logic [csx_pkg::DATA_W-1:0]  opt_next;
	logic                        zero_reg;
	logic                        zero_next;
	logic [csx_pkg::PC_W-1:0]    pc_reg;
	logic [csx_pkg::PC_W-1:0]    pc_next;

	logic                        retire_reg;
	logic                        retire_next;
	logic                        discard_reg;
	logic                        discard_next;
	logic                        ret_reg;
	logic                        ret_next;
	logic                        fwe_reg;
	logic                        fwe_next;
	logic [csx_pkg::ADDR_W-1:0]  fwa_reg;
	logic [csx_pkg::ADDR_W-1:0]  fwa_next;
	logic [csx_pkg::DATA_W-1:0]  fwd_reg;
	logic [csx_pkg::DATA_W-1:0]  fwd_next;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	assign opc = instr[csx_pkg::OPC_MSB:csx_pkg::OPC_LSB];

	always_comb begin
		dec       = '0;
		dec.op    = csx_pkg::CSX_OP_IDLE;
		dec.dest  = instr[csx_pkg::DEST_BIT];
		dec.faddr = instr[csx_pkg::FADDR_MSB:csx_pkg::FADDR_LSB];
		dec.lit   = instr[csx_pkg::LIT_MSB:csx_pkg::LIT_LSB];
		unique case (opc)
			csx_pkg::OPC_MISC: begin
				if (instr[csx_pkg::LIT_MSB:csx_pkg::LIT_LSB] == csx_pkg::MISC_OPTION) begin
					dec.op = csx_pkg::CSX_OP_OPTION;
				end else begin
					// Unlisted minor codes fall to idle
					dec.op = csx_pkg::CSX_OP_IDLE;
				end
			end
			csx_pkg::OPC_STORE: begin
				dec.op   = csx_pkg::CSX_OP_STORE;
				// No destination bit on a store; force file
				dec.dest = csx_pkg::DEST_FILE;
			end
			csx_pkg::OPC_ORF: begin
				dec.op = csx_pkg::CSX_OP_OR_FILE;
			end
			csx_pkg::OPC_COPY: begin
				dec.op = csx_pkg::CSX_OP_COPY;
			end
			csx_pkg::OPC_INCSZ: begin
				dec.op = csx_pkg::CSX_OP_INC_SKIP;
			end
			csx_pkg::OPC_RET: begin
				dec.op = csx_pkg::CSX_OP_RETURN;
			end
			csx_pkg::OPC_MOVL: begin
				dec.op = csx_pkg::CSX_OP_LOAD_LIT;
			end
			csx_pkg::OPC_ORL: begin
				dec.op = csx_pkg::CSX_OP_OR_LIT;
			end
			default: begin
				// Opcodes outside this subset act as idle
				dec.op = csx_pkg::CSX_OP_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Issue control
	// ----------------------------------------------------------------
	assign flush_now = instr_valid && (state_reg == CSX_ST_FLUSH);
	assign exec_now  = instr_valid && (state_reg == CSX_ST_EXEC);

	// Discarded word is replaced by idle, so nothing it asks for happens
	always_comb begin
		dec_eff = dec;
		if (!exec_now) begin
			dec_eff    = '0;
			dec_eff.op = csx_pkg::CSX_OP_IDLE;
		end
	end

	// ----------------------------------------------------------------
	// Datapath
	// ----------------------------------------------------------------
	csx_file_regs u_file (
		.ref_clk (ref_clk),
		.srst    (srst),
		.wr_en   (res.file_we),
		.wr_addr (dec_eff.faddr),
		.wr_data (res.data),
		.rd_addr (dec_eff.faddr),
		.rd_data (fval)
	);

	csx_alu u_alu (
		.dec  (dec_eff),
		.acc  (acc_reg),
		.fval (fval),
		.res  (res)
	);

	// ----------------------------------------------------------------
	// Sequencing
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			CSX_ST_EXEC: begin
				if (exec_now && (res.skip || res.ret)) begin
					state_next = CSX_ST_FLUSH;
				end else begin
					state_next = CSX_ST_EXEC;
				end
			end
			CSX_ST_FLUSH: begin
				// Idle gaps leave the discard slot pending
				if (instr_valid) begin
					state_next = CSX_ST_EXEC;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_reg <= CSX_ST_EXEC;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// Program counter
	// ----------------------------------------------------------------
	always_comb begin
		pc_next = pc_reg;
		// A dropped word still counts as a fetch
		if (exec_now && res.ret) begin
			pc_next = stack_top;
		end else if (instr_valid) begin
			pc_next = pc_reg + csx_pkg::PC_STEP;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pc_reg <= csx_pkg::PC_RST;
		end else begin
			pc_reg <= pc_next;
		end
	end

	// ----------------------------------------------------------------
	// Accumulator and option
	// ----------------------------------------------------------------
	always_comb begin
		acc_next = acc_reg;
		opt_next = opt_reg;
		if (res.acc_we) begin
			acc_next = res.data;
		end
		if (res.opt_we) begin
			opt_next = res.data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			acc_reg <= csx_pkg::ACC_RST;
			opt_reg <= csx_pkg::OPT_RST;
		end else begin
			acc_reg <= acc_next;
			opt_reg <= opt_next;
		end
	end

	// ----------------------------------------------------------------
	// Zero flag
	// ----------------------------------------------------------------
	always_comb begin
		zero_next = zero_reg;
		// Flag writes only where the op asks; others keep it
		if (res.zero_we) begin
			zero_next = res.zero_val;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			zero_reg <= 1'b0;
		end else begin
			zero_reg <= zero_next;
		end
	end

	// ----------------------------------------------------------------
	// Event pulses
	// ----------------------------------------------------------------
	always_comb begin
		retire_next  = exec_now;
		discard_next = flush_now;
		ret_next     = exec_now && res.ret;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			retire_reg  <= 1'b0;
			discard_reg <= 1'b0;
			ret_reg     <= 1'b0;
		end else begin
			retire_reg  <= retire_next;
			discard_reg <= discard_next;
			ret_reg     <= ret_next;
		end
	end

	// ----------------------------------------------------------------
	// File write echo
	// ----------------------------------------------------------------
	// Address follows decode even without a write; only the enable qualifies it
	always_comb begin
		fwe_next = res.file_we;
		fwa_next = dec_eff.faddr;
		fwd_next = res.data;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			fwe_reg <= 1'b0;
			fwa_reg <= '0;
			fwd_reg <= csx_pkg::ZERO_B;
		end else begin
			fwe_reg <= fwe_next;
			fwa_reg <= fwa_next;
			fwd_reg <= fwd_next;
		end
	end

	// ----------------------------------------------------------------
	// Port drive
	// ----------------------------------------------------------------
	assign acc          = acc_reg;
	assign option_cfg   = opt_reg;
	assign zero_flag    = zero_reg;
	assign pc           = pc_reg;
	assign retire       = retire_reg;
	assign discard      = discard_reg;
	assign pc_return    = ret_reg;
	assign file_wr_en   = fwe_reg;
	assign file_wr_addr = fwa_reg;
	assign file_wr_data = fwd_reg;

endmodule
`default_nettype wire

// File: design/csx_pkg.sv
// Shared constants, encodings and carrier types of the instruction execution core
package csx_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int DATA_W  = 8;
	localparam int ADDR_W  = 5;
	localparam int PC_W    = 9;
	localparam int INSTR_W = 12;
	localparam int FILE_N  = 32;

	// ----------------------------------------------------------------
	// Instruction word fields
	// ----------------------------------------------------------------
	localparam int OPC_MSB   = 11;
	localparam int OPC_LSB   = 8;
	localparam int DEST_BIT  = 5;
	localparam int FADDR_MSB = 4;
	localparam int FADDR_LSB = 0;
	localparam int LIT_MSB   = 7;
	localparam int LIT_LSB   = 0;

	// ----------------------------------------------------------------
	// Major opcodes, bits 11:8
	// ----------------------------------------------------------------
	localparam logic [3:0] OPC_MISC  = 4'h0;
	localparam logic [3:0] OPC_STORE = 4'h1;
	localparam logic [3:0] OPC_ORF   = 4'h2;
	localparam logic [3:0] OPC_COPY  = 4'h3;
	localparam logic [3:0] OPC_INCSZ = 4'h4;
	localparam logic [3:0] OPC_RET   = 4'h8;
	localparam logic [3:0] OPC_MOVL  = 4'hc;
	localparam logic [3:0] OPC_ORL   = 4'hd;

	// Minor codes under OPC_MISC, bits 7:0
	localparam logic [7:0] MISC_IDLE   = 8'h00;
	localparam logic [7:0] MISC_OPTION = 8'h02;

	// Destination select
	localparam logic DEST_ACC  = 1'b0;
	localparam logic DEST_FILE = 1'b1;

	// ----------------------------------------------------------------
	// Reset values and fixed constants
	// ----------------------------------------------------------------
	localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
	localparam logic [DATA_W-1:0] OPT_RST  = 8'hff;
	localparam logic [DATA_W-1:0] FILE_RST = 8'h00;
	localparam logic [DATA_W-1:0] ONE_B    = 8'h01;
	localparam logic [DATA_W-1:0] ZERO_B   = 8'h00;
	localparam logic [PC_W-1:0]   PC_RST   = 9'h000;
	localparam logic [PC_W-1:0]   PC_STEP  = 9'h001;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		CSX_OP_IDLE,
		CSX_OP_OPTION,
		CSX_OP_STORE,
		CSX_OP_OR_FILE,
		CSX_OP_COPY,
		CSX_OP_INC_SKIP,
		CSX_OP_RETURN,
		CSX_OP_LOAD_LIT,
		CSX_OP_OR_LIT
	} csx_op_e;

	typedef struct packed {
		csx_op_e             op;
		logic                dest;
		logic [ADDR_W-1:0]   faddr;
		logic [DATA_W-1:0]   lit;
	} csx_dec_s;

	typedef struct packed {
		logic                acc_we;
		logic                file_we;
		logic                opt_we;
		logic                zero_we;
		logic                zero_val;
		logic                skip;
		logic                ret;
		logic [DATA_W-1:0]   data;
	} csx_res_s;

endpackage

// File: design/csx_file_regs.sv
// File register array of the execution core, one write and one read port
`timescale 1ns/1ps
`default_nettype none
module csx_file_regs (
	input  wire logic                        ref_clk,
	input  wire logic                        srst,
	input  wire logic                        wr_en,
	input  wire logic [csx_pkg::ADDR_W-1:0]  wr_addr,
	input  wire logic [csx_pkg::DATA_W-1:0]  wr_data,
	input  wire logic [csx_pkg::ADDR_W-1:0]  rd_addr,
	output logic      [csx_pkg::DATA_W-1:0]  rd_data
);

	logic [csx_pkg::DATA_W-1:0] mem_reg  [csx_pkg::FILE_N];
	logic [csx_pkg::DATA_W-1:0] mem_next [csx_pkg::FILE_N];

	// ----------------------------------------------------------------
	// Storage, one entry per location
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < csx_pkg::FILE_N; gi++) begin : g_ent
			localparam int ENT_IDX = gi;

			always_comb begin
				mem_next[gi] = mem_reg[gi];
				if (wr_en && (wr_addr == ENT_IDX[csx_pkg::ADDR_W-1:0])) begin
					mem_next[gi] = wr_data;
				end
			end

			always_ff @(posedge ref_clk) begin
				if (srst) begin
					mem_reg[gi] <= csx_pkg::FILE_RST;
				end else begin
					mem_reg[gi] <= mem_next[gi];
				end
			end
		end
	endgenerate

	// Read sees the old value in the writing cycle
	assign rd_data = mem_reg[rd_addr];

endmodule
`default_nettype wire

// File: design/csx_alu.sv
// Result and flag computation for one decoded instruction
`timescale 1ns/1ps
`default_nettype none
module csx_alu (
	input  wire csx_pkg::csx_dec_s           dec,
	input  wire logic [csx_pkg::DATA_W-1:0]  acc,
	input  wire logic [csx_pkg::DATA_W-1:0]  fval,
	output var csx_pkg::csx_res_s            res
);

	logic [csx_pkg::DATA_W-1:0] sum;
	logic                       to_file;

	assign sum     = fval + csx_pkg::ONE_B;
	assign to_file = (dec.dest == csx_pkg::DEST_FILE);

	always_comb begin
		res = '0;
		unique case (dec.op)
			csx_pkg::CSX_OP_IDLE: begin
				res.data = csx_pkg::ZERO_B;
			end
			csx_pkg::CSX_OP_OPTION: begin
				res.data   = acc;
				res.opt_we = 1'b1;
			end
			csx_pkg::CSX_OP_STORE: begin
				res.data    = acc;
				res.file_we = 1'b1;
			end
			csx_pkg::CSX_OP_OR_FILE: begin
				res.data    = acc | fval;
				res.file_we = to_file;
				res.acc_we  = !to_file;
				res.zero_we = 1'b1;
			end
			csx_pkg::CSX_OP_COPY: begin
				res.data    = fval;
				res.file_we = to_file;
				res.acc_we  = !to_file;
				res.zero_we = 1'b1;
			end
			csx_pkg::CSX_OP_INC_SKIP: begin
				res.data    = sum;
				res.file_we = to_file;
				res.acc_we  = !to_file;
				res.skip    = (sum == csx_pkg::ZERO_B);
			end
			csx_pkg::CSX_OP_RETURN: begin
				res.data   = dec.lit;
				res.acc_we = 1'b1;
				res.ret    = 1'b1;
			end
			csx_pkg::CSX_OP_LOAD_LIT: begin
				res.data   = dec.lit;
				res.acc_we = 1'b1;
			end
			csx_pkg::CSX_OP_OR_LIT: begin
				res.data    = acc | dec.lit;
				res.acc_we  = 1'b1;
				res.zero_we = 1'b1;
			end
		endcase
		res.zero_val = (res.data == csx_pkg::ZERO_B);
	end

endmodule
`default_nettype wire

// File: test/csx_core_checker.sv
// Port-level assertions for the execution core
`timescale 1ns/1ps
`default_nettype none
module csx_core_checker (
	input wire logic        ref_clk,
	input wire logic        srst,
	input wire logic        instr_valid,
	input wire logic [11:0] instr,
	input wire logic [8:0]  stack_top,
	input wire logic [7:0]  acc,
	input wire logic [7:0]  option_cfg,
	input wire logic        zero_flag,
	input wire logic [8:0]  pc,
	input wire logic        retire,
	input wire logic        discard,
	input wire logic        pc_return,
	input wire logic        file_wr_en,
	input wire logic [4:0]  file_wr_addr,
	input wire logic [7:0]  file_wr_data
);
	// ----------------------------------------
	// Previous-cycle copies
	// ----------------------------------------
	logic [11:0] p_ins;
	logic [7:0]  p_acc;
	logic        p_zf;
	logic [8:0]  p_st;
	always_ff @(posedge ref_clk) begin
		p_ins <= instr;
		p_acc <= acc;
		p_zf  <= zero_flag;
		p_st  <= stack_top;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	chk_load_lit: assert property (retire && p_ins[11:8] == csx_pkg::OPC_MOVL |-> acc == p_ins[7:0] && zero_flag == p_zf)
		else $error("load literal wrong");
	chk_or_lit: assert property (retire && p_ins[11:8] == csx_pkg::OPC_ORL |-> acc == (p_acc | p_ins[7:0]))
		else $error("or literal wrong");
	chk_zero_follows: assert property (retire && p_ins[11:8] == csx_pkg::OPC_ORL |-> zero_flag == (acc == 8'h00))
		else $error("zero flag wrong");
	chk_store_acc: assert property (retire && p_ins[11:8] == csx_pkg::OPC_STORE |->
		file_wr_en && file_wr_addr == p_ins[4:0] && file_wr_data == p_acc && zero_flag == p_zf)
		else $error("store wrong");
	chk_inc_noflag: assert property (retire && p_ins[11:8] == csx_pkg::OPC_INCSZ |-> zero_flag == p_zf)
		else $error("increment touched flag");
	chk_option_load: assert property (retire && p_ins == 12'h002 |-> option_cfg == p_acc && zero_flag == p_zf)
		else $error("option load wrong");
	chk_return_pc: assert property (retire && p_ins[11:8] == csx_pkg::OPC_RET |->
		pc_return && pc == p_st && acc == p_ins[7:0])
		else $error("return wrong");
	chk_return_skip: assert property (pc_return && instr_valid |=> discard && !retire)
		else $error("return slot kept");
	chk_discard_quiet: assert property (discard |-> !file_wr_en && $stable(acc) && $stable(zero_flag))
		else $error("discard changed state");
	chk_one_outcome: assert property ($past(instr_valid) && !$past(srst) |-> retire != discard)
		else $error("word neither run nor dropped");
	chk_idle_quiet: assert property (retire && p_ins == 12'h000 |->
		!file_wr_en && acc == p_acc && zero_flag == p_zf)
		else $error("idle changed state");
	cov_skip: cover property (discard && !pc_return);
	cov_return: cover property (pc_return ##1 discard);
	cov_option: cover property (retire && p_ins == 12'h002);
endmodule
bind csx_core csx_core_checker chk_u (.ref_clk(ref_clk), .srst(srst), .instr_valid(instr_valid), .instr(instr),
	.stack_top(stack_top), .acc(acc), .option_cfg(option_cfg), .zero_flag(zero_flag), .pc(pc), .retire(retire),
	.discard(discard), .pc_return(pc_return), .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr),
	.file_wr_data(file_wr_data));
`default_nettype wire

// File: test/csx_core_tb_top.sv
// Self-checking bench for the execution core
`timescale 1ns/1ps
`default_nettype none
module csx_core_tb_top;
	logic        ref_clk = 1'b0;
	logic        srst = 1'b1;
	logic        instr_valid = 1'b0;
	logic [11:0] instr = 12'h000;
	logic [8:0]  stack_top = 9'h000;
	logic [7:0]  acc;
	logic [7:0]  option_cfg;
	logic        zero_flag;
	logic [8:0]  pc;
	logic        retire;
	logic        discard;
	logic        pc_return;
	logic        file_wr_en;
	logic [4:0]  file_wr_addr;
	logic [7:0]  file_wr_data;
	int          err_count = 0;
	int          n_compared = 0;
	int          cycles = 0;

	always #4 ref_clk = ~ref_clk;

	csx_core dut_u (
		.ref_clk      (ref_clk),
		.srst         (srst),
		.instr_valid  (instr_valid),
		.instr        (instr),
		.stack_top    (stack_top),
		.acc          (acc),
		.option_cfg   (option_cfg),
		.zero_flag    (zero_flag),
		.pc           (pc),
		.retire       (retire),
		.discard      (discard),
		.pc_return    (pc_return),
		.file_wr_en   (file_wr_en),
		.file_wr_addr (file_wr_addr),
		.file_wr_data (file_wr_data)
	);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Outputs seen after feed belong to the word before it
	task automatic feed(input logic [11:0] w);
		@(posedge ref_clk);
		instr_valid <= 1'b1;
		instr <= w;
		@(negedge ref_clk);
	endtask

	task automatic quiet();
		@(posedge ref_clk);
		instr_valid <= 1'b0;
		@(negedge ref_clk);
	endtask

	task automatic exec(input logic [11:0] w);
		feed(w);
		quiet();
	endtask

	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		cmp(acc, 8'h00);
		cmp(option_cfg, 8'hff);
		cmp(zero_flag, 1'b0);
		cmp(pc, 9'h000);
		$display("test reset done");
	endtask

	task automatic t_move();
		exec(12'hca5);
		cmp(acc, 8'ha5);
		exec(12'h11f);
		cmp({file_wr_en, file_wr_addr, file_wr_data}, {1'b1, 5'h1f, 8'ha5});
		exec(12'hc00);
		exec(12'h31f);
		cmp({acc, zero_flag}, {8'ha5, 1'b0});
		exec(12'h327);
		cmp({acc, zero_flag, file_wr_data}, {8'ha5, 1'b1, 8'h00});
		exec(12'hcff);
		cmp(zero_flag, 1'b1);
		$display("test move done");
	endtask

	task automatic t_or();
		exec(12'hd01);
		cmp({acc, zero_flag}, {8'hff, 1'b0});
		exec(12'hc00);
		exec(12'hd00);
		cmp(zero_flag, 1'b1);
		exec(12'hd3c);
		cmp({acc, zero_flag}, {8'h3c, 1'b0});
		exec(12'h21f);
		cmp(acc, 8'hbd);
		exec(12'h23f);
		cmp({file_wr_en, file_wr_addr, file_wr_data, acc}, {1'b1, 5'h1f, 8'hbd, 8'hbd});
		$display("test or done");
	endtask

	task automatic t_option_idle();
		logic [8:0] p;
		exec(12'hc5a);
		exec(12'h002);
		cmp(option_cfg, 8'h5a);
		p = pc;
		exec(12'h000);
		cmp({pc, acc, option_cfg, retire, file_wr_en}, {p + 9'h001, 8'h5a, 8'h5a, 1'b1, 1'b0});
		$display("test option idle done");
	endtask

	task automatic t_skip();
		logic z;
		exec(12'hcff);
		exec(12'h103);
		z = zero_flag;
		feed(12'h463);
		feed(12'hc77);
		cmp({retire, file_wr_data, acc, zero_flag}, {1'b1, 8'h00, 8'hff, z});
		quiet();
		cmp({discard, retire, acc}, {1'b1, 1'b0, 8'hff});
		exec(12'hc10);
		exec(12'h104);
		feed(12'h404);
		feed(12'hc66);
		cmp(acc, 8'h11);
		quiet();
		cmp({discard, acc}, {1'b0, 8'h66});
		$display("test skip done");
	endtask

	task automatic t_return();
		logic z;
		@(posedge ref_clk);
		stack_top <= 9'h1a0;
		z = zero_flag;
		feed(12'h842);
		feed(12'hc99);
		cmp({pc, acc, pc_return, zero_flag}, {9'h1a0, 8'h42, 1'b1, z});
		quiet();
		cmp({discard, acc, pc}, {1'b1, 8'h42, 9'h1a1});
		$display("test return done");
	endtask

	// Reset lands while a discard slot is pending; the slot must not survive it
	task automatic t_mid_reset();
		@(posedge ref_clk);
		stack_top <= 9'h0f0;
		feed(12'h8aa);
		@(posedge ref_clk);
		srst        <= 1'b1;
		instr_valid <= 1'b0;
		@(posedge ref_clk);
		srst <= 1'b0;
		@(negedge ref_clk);
		cmp({acc, option_cfg, zero_flag, pc, pc_return}, {8'h00, 8'hff, 1'b0, 9'h000, 1'b0});
		exec(12'hc3c);
		cmp({acc, retire, discard}, {8'h3c, 1'b1, 1'b0});
		$display("test mid reset done");
	endtask

	// ----------------------------------------
	// Run control
	// ----------------------------------------
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			tally_and_finish();
		end
	end

	initial begin
		repeat (3) @(posedge ref_clk);
		srst <= 1'b0;
		@(negedge ref_clk);
		t_reset();
		t_move();
		t_or();
		t_option_idle();
		t_skip();
		t_return();
		t_mid_reset();
		tally_and_finish();
	end
endmodule
`default_nettype wire
